// File: ptpr_mac_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// mac receive and transmit path model
// ------------------------------------------------------------
module ptpr_mac_model
(
	input wire logic hclk,
	output ptpr_pkg::ptpr_rx_evt_s rx_evt,
	output ptpr_pkg::ptpr_tx_frame_s tx_frame
);
	// quiet paths at time zero
	initial
	begin
		rx_evt <= '0;
		tx_frame <= '0;
	end

	// one-cycle receive event; the correction bus is scrambled once the pulse ends
	// so a design that samples it outside the pulse reads junk
	task automatic send_rx(input logic c, input logic f, input logic p, input logic [63:0] corr);
		rx_evt <= {p, corr, c, f};
		@(posedge hclk);
		rx_evt <= {1'b0, ~corr, 1'b0, 1'b0};
	endtask

	// one-cycle transmit frame header; address fields inverted after valid drops, kind kept
	task automatic send_tx(input ptpr_pkg::ptpr_kind_e k, input logic [47:0] m,
		input logic [31:0] a4, input logic [127:0] a6);
		tx_frame <= {1'b1, k, m, a4, a6};
		@(posedge hclk);
		tx_frame <= {1'b0, k, ~m, ~a4, ~a6};
	endtask
endmodule // ptpr_mac_model

// File: ptpr_pkg.sv
package ptpr_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [8:0] OFS_TX_DETECT = 9'h158;
	localparam logic [8:0] OFS_CORR_HIGH = 9'h180;
	localparam logic [8:0] OFS_CORR_LOW = 9'h184;
	localparam logic [8:0] OFS_CHK_DROP = 9'h188;
	localparam logic [8:0] OFS_FLT_DROP = 9'h18c;
	localparam logic [8:0] OFS_REFRESH = 9'h1f8;
	localparam logic [8:0] OFS_BANK_SEL = 9'h1fc;
	localparam logic [2:0] BANK_PORT1 = 3'h1;
	localparam logic [2:0] BANK_PORT2 = 3'h2;
	localparam logic [2:0] BANK_SEL_RST = 3'h1;
	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int TXD_L2_PEER = 14;
	localparam int TXD_L2_GEN = 13;
	localparam int TXD_PAIR_ONE = 12;
	localparam int TXD_PAIR_TWO = 11;
	localparam int REFRESH_BIT = 31;
	localparam logic [31:0] TX_DETECT_RST = 32'h0000_7000;
	localparam logic [31:0] TX_DETECT_MASK = 32'h0000_7800;
	localparam logic [31:0] CORR_LOW_MASK = 32'hffff_0000;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [31:0] COUNT_MAX = 32'hffff_ffff;
	// ------------------------------------------------------------
	// destination addresses
	// ------------------------------------------------------------
	localparam logic [47:0] MAC_L2_PEER = 48'h0180_c200_000e;
	localparam logic [47:0] MAC_L2_GEN = 48'h011b_1900_0000;
	localparam logic [47:0] MAC_V4_ONE = 48'h0100_5e00_0181;
	localparam logic [47:0] MAC_V4_TWO = 48'h0100_5e00_0182;
	localparam logic [47:0] MAC_V6_ONE = 48'h3333_0000_0181;
	localparam logic [47:0] MAC_V6_TWO = 48'h3333_0000_0182;
	localparam logic [31:0] IP4_ONE = 32'he000_0181;
	localparam logic [31:0] IP4_TWO = 32'he000_0182;
	localparam logic [127:0] IP6_ONE = 128'hff00_0000_0000_0000_0000_0000_0000_0181;
	localparam logic [127:0] IP6_TWO = 128'hff00_0000_0000_0000_0000_0000_0000_0182;
	// scope nibble is a wildcard
	localparam logic [127:0] IP6_MASK = 128'hfff0_ffff_ffff_ffff_ffff_ffff_ffff_ffff;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {KIND_L2, KIND_IPV4, KIND_IPV6, KIND_OTHER} ptpr_kind_e;
	typedef struct packed {
		logic valid;
		ptpr_kind_e kind;
		logic [47:0] mac;
		logic [31:0] ip4;
		logic [127:0] ip6;
	} ptpr_tx_frame_s;
	typedef struct packed {
		logic pdreq_valid;
		logic [63:0] correction;
		logic chk_drop;
		logic flt_drop;
	} ptpr_rx_evt_s;
endpackage

// File: ptpr_regs.sv
`timescale 1ns/10ps
module ptpr_regs
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire ptpr_pkg::ptpr_rx_evt_s rx_evt,
	output logic rx_frame_error,
	input wire ptpr_pkg::ptpr_tx_frame_s tx_frame,
	output logic tx_is_ptp_valid,
	output logic tx_is_ptp
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// counters stop at all-ones so a long-running tally never reads small again
	function automatic logic [31:0] sat_inc(input logic [31:0] v, input logic ev);
		sat_inc = (ev && (v != ptpr_pkg::COUNT_MAX)) ? v + 32'h0000_0001 : v;
	endfunction

	// ipv6 compare ignores the multicast scope nibble
	function automatic logic ip6_hit(input logic [127:0] a, input logic [127:0] b);
		ip6_hit = ((a ^ b) & ptpr_pkg::IP6_MASK) == 128'h0;
	endfunction

	// ------------------------------------------------------------
	// bus slave: address phase capture
	// ------------------------------------------------------------
	logic ph_wr;
	logic ph_rd;
	logic [8:0] ph_ofs;
	logic [2:0] bank_sel;
	logic refresh_en;
	logic [31:0] corr_high;
	logic [15:0] corr_low;
	logic [31:0] chk_count;
	logic [31:0] flt_count;
	logic [3:0] tx_detect;

	wire logic ap_valid = hsel && htrans[1] && hready;
	wire logic [8:0] ap_ofs = {haddr[8:2], 2'b00};

	// zero wait states, never an error
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ph_wr <= 1'b0;
			ph_ofs <= 9'h000;
		end
		else
		begin
			ph_wr <= ap_valid && hwrite;
			ph_ofs <= ap_ofs;
		end
	end

	// ------------------------------------------------------------
	// decode: bank select is visible in every bank
	// ------------------------------------------------------------
	function automatic logic hit(input logic [8:0] ofs, input logic [8:0] want,
		input logic [2:0] bank, input logic [2:0] need);
		hit = (ofs == want) && (bank == need);
	endfunction

	wire logic [2:0] bk = bank_sel;
	wire logic wr_bank = ph_wr && (ph_ofs == ptpr_pkg::OFS_BANK_SEL);
	wire logic wr_tx_detect = ph_wr && hit(ph_ofs, ptpr_pkg::OFS_TX_DETECT, bk,
		ptpr_pkg::BANK_PORT2);
	wire logic wr_corr_high = ph_wr && hit(ph_ofs, ptpr_pkg::OFS_CORR_HIGH, bk,
		ptpr_pkg::BANK_PORT1);
	wire logic wr_corr_low = ph_wr && hit(ph_ofs, ptpr_pkg::OFS_CORR_LOW, bk,
		ptpr_pkg::BANK_PORT1);
	wire logic wr_chk = ph_wr && hit(ph_ofs, ptpr_pkg::OFS_CHK_DROP, bk, ptpr_pkg::BANK_PORT1);
	wire logic wr_flt = ph_wr && hit(ph_ofs, ptpr_pkg::OFS_FLT_DROP, bk, ptpr_pkg::BANK_PORT1);
	wire logic wr_refresh = ph_wr && hit(ph_ofs, ptpr_pkg::OFS_REFRESH, bk,
		ptpr_pkg::BANK_PORT1);

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bank_sel <= ptpr_pkg::BANK_SEL_RST;
			refresh_en <= 1'b0;
			tx_detect <= ptpr_pkg::TX_DETECT_RST[ptpr_pkg::TXD_L2_PEER:ptpr_pkg::TXD_PAIR_TWO];
		end
		else
		begin
			if (wr_bank)
				bank_sel <= hwdata[2:0];
			if (wr_refresh)
				refresh_en <= hwdata[ptpr_pkg::REFRESH_BIT];
			if (wr_tx_detect)
				tx_detect <= hwdata[ptpr_pkg::TXD_L2_PEER:ptpr_pkg::TXD_PAIR_TWO];
		end
	end

	// ------------------------------------------------------------
	// correction value: hardware capture beats a same-cycle write
	// ------------------------------------------------------------
	wire logic corr_load = rx_evt.pdreq_valid && refresh_en;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			corr_high <= ptpr_pkg::WORD_ZERO;
			corr_low <= 16'h0000;
		end
		else if (corr_load)
		begin
			corr_high <= rx_evt.correction[63:32];
			corr_low <= rx_evt.correction[31:16]; // fraction bits 15:0 dropped
		end
		else
		begin
			if (wr_corr_high)
				corr_high <= hwdata;
			if (wr_corr_low)
				corr_low <= hwdata[31:16];
		end
	end

	// ------------------------------------------------------------
	// drop counters: a write sets the base, the event still counts
	// ------------------------------------------------------------
	wire logic [31:0] chk_base = wr_chk ? hwdata : chk_count;
	wire logic [31:0] flt_base = wr_flt ? hwdata : flt_count;
	wire logic [31:0] next_chk = sat_inc(chk_base, rx_evt.chk_drop);
	wire logic [31:0] next_flt = sat_inc(flt_base, rx_evt.flt_drop);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			chk_count <= ptpr_pkg::WORD_ZERO;
			flt_count <= ptpr_pkg::WORD_ZERO;
			rx_frame_error <= 1'b0;
		end
		else
		begin
			chk_count <= next_chk;
			flt_count <= next_flt;
			rx_frame_error <= rx_evt.chk_drop || rx_evt.flt_drop;
		end
	end

	// ------------------------------------------------------------
	// transmit PTP detection
	// ------------------------------------------------------------
	wire logic is_l2 = tx_frame.kind == ptpr_pkg::KIND_L2;
	wire logic is_v4 = tx_frame.kind == ptpr_pkg::KIND_IPV4;
	wire logic is_v6 = tx_frame.kind == ptpr_pkg::KIND_IPV6;
	wire logic m_peer = is_l2 && (tx_frame.mac == ptpr_pkg::MAC_L2_PEER);
	wire logic m_gen = is_l2 && (tx_frame.mac == ptpr_pkg::MAC_L2_GEN);
	wire logic m_one = (is_v4 && (tx_frame.mac == ptpr_pkg::MAC_V4_ONE)
		&& (tx_frame.ip4 == ptpr_pkg::IP4_ONE))
		|| (is_v6 && (tx_frame.mac == ptpr_pkg::MAC_V6_ONE)
		&& ip6_hit(tx_frame.ip6, ptpr_pkg::IP6_ONE));
	wire logic m_two = (is_v4 && (tx_frame.mac == ptpr_pkg::MAC_V4_TWO)
		&& (tx_frame.ip4 == ptpr_pkg::IP4_TWO))
		|| (is_v6 && (tx_frame.mac == ptpr_pkg::MAC_V6_TWO)
		&& ip6_hit(tx_frame.ip6, ptpr_pkg::IP6_TWO));
	wire logic en_peer = tx_detect[ptpr_pkg::TXD_L2_PEER - ptpr_pkg::TXD_PAIR_TWO];
	wire logic en_gen = tx_detect[ptpr_pkg::TXD_L2_GEN - ptpr_pkg::TXD_PAIR_TWO];
	wire logic en_one = tx_detect[ptpr_pkg::TXD_PAIR_ONE - ptpr_pkg::TXD_PAIR_TWO];
	wire logic en_two = tx_detect[0];
	wire logic tx_hit = (en_peer && m_peer)
		|| (en_gen && m_gen)
		|| (en_one && m_one)
		|| (en_two && m_two);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tx_is_ptp_valid <= 1'b0;
			tx_is_ptp <= 1'b0;
		end
		else
		begin
			tx_is_ptp_valid <= tx_frame.valid;
			tx_is_ptp <= tx_frame.valid && tx_hit;
		end
	end

	// ------------------------------------------------------------
	// read mux, registered at the address phase
	// ------------------------------------------------------------
	logic [31:0] rd_mux;

	always_comb
	begin
		rd_mux = ptpr_pkg::WORD_ZERO;
		if (ap_ofs == ptpr_pkg::OFS_BANK_SEL)
			rd_mux = {29'h0, bank_sel};
		else if (bank_sel == ptpr_pkg::BANK_PORT2)
		begin
			if (ap_ofs == ptpr_pkg::OFS_TX_DETECT)
				rd_mux = {17'h0, tx_detect, 11'h0} & ptpr_pkg::TX_DETECT_MASK;
		end
		else if (bank_sel == ptpr_pkg::BANK_PORT1)
		begin
			case (ap_ofs)
				ptpr_pkg::OFS_CORR_HIGH: rd_mux = corr_high;
				ptpr_pkg::OFS_CORR_LOW:
					rd_mux = {corr_low, 16'h0} & ptpr_pkg::CORR_LOW_MASK;
				ptpr_pkg::OFS_CHK_DROP: rd_mux = chk_count;
				ptpr_pkg::OFS_FLT_DROP: rd_mux = flt_count;
				ptpr_pkg::OFS_REFRESH: rd_mux = {refresh_en, 31'h0};
				default: rd_mux = ptpr_pkg::WORD_ZERO;
			endcase
		end
	end

	// a read issued right after a write to the same word is not forwarded;
	// the master inserts an idle cycle between transfers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ph_rd <= 1'b0;
			hrdata <= ptpr_pkg::WORD_ZERO;
		end
		else
		begin
			ph_rd <= ap_valid && !hwrite;
			if (ap_valid && !hwrite)
				hrdata <= rd_mux;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_corr_capture;
		@(posedge hclk) disable iff (!hresetn)
		corr_load |=> (corr_high == $past(rx_evt.correction[63:32]))
			&& (corr_low == $past(rx_evt.correction[31:16]));
	endproperty
	a_corr_capture: assert property (p_corr_capture) else $error("correction not captured");

	property p_corr_low_read;
		@(posedge hclk) disable iff (!hresetn)
		ph_rd && (ph_ofs == ptpr_pkg::OFS_CORR_LOW) |-> (hrdata[15:0] == 16'h0000);
	endproperty
	a_corr_low_read: assert property (p_corr_low_read) else $error("reserved bits not zero");

	property p_corr_hold;
		@(posedge hclk) disable iff (!hresetn)
		!refresh_en && !wr_corr_high |=> $stable(corr_high);
	endproperty
	a_corr_hold: assert property (p_corr_hold) else $error("correction moved");

	property p_chk_inc;
		@(posedge hclk) disable iff (!hresetn)
		rx_evt.chk_drop && !wr_chk && (chk_count != ptpr_pkg::COUNT_MAX)
			|=> chk_count == $past(chk_count) + 32'h0000_0001;
	endproperty
	a_chk_inc: assert property (p_chk_inc) else $error("checksum count missed");

	property p_flt_inc;
		@(posedge hclk) disable iff (!hresetn)
		rx_evt.flt_drop && !wr_flt && (flt_count != ptpr_pkg::COUNT_MAX)
			|=> flt_count == $past(flt_count) + 32'h0000_0001;
	endproperty
	a_flt_inc: assert property (p_flt_inc) else $error("filter count missed");

	property p_saturate;
		@(posedge hclk) disable iff (!hresetn)
		(chk_count == ptpr_pkg::COUNT_MAX) && !wr_chk |=> chk_count == ptpr_pkg::COUNT_MAX;
	endproperty
	a_saturate: assert property (p_saturate) else $error("counter wrapped");

	property p_clear;
		@(posedge hclk) disable iff (!hresetn)
		wr_flt && (hwdata == ptpr_pkg::WORD_ZERO) |=> flt_count == {31'h0, $past(rx_evt.flt_drop)};
	endproperty
	a_clear: assert property (p_clear) else $error("counter not cleared");

	property p_frame_error;
		@(posedge hclk) disable iff (!hresetn)
		rx_evt.chk_drop || rx_evt.flt_drop |=> rx_frame_error;
	endproperty
	a_frame_error: assert property (p_frame_error) else $error("drop not flagged");

	property p_peer_detect;
		@(posedge hclk) disable iff (!hresetn)
		tx_frame.valid && m_peer && en_peer |=> tx_is_ptp && tx_is_ptp_valid;
	endproperty
	a_peer_detect: assert property (p_peer_detect) else $error("peer frame missed");

	property p_no_enable;
		@(posedge hclk) disable iff (!hresetn)
		tx_frame.valid && !(en_gen && m_gen) && !(en_peer && m_peer) && !(en_one && m_one)
			&& !(en_two && m_two) |=> !tx_is_ptp;
	endproperty
	a_no_enable: assert property (p_no_enable) else $error("frame wrongly marked");

	property p_bank_guard;
		@(posedge hclk) disable iff (!hresetn)
		ph_wr && (ph_ofs == ptpr_pkg::OFS_CORR_HIGH) && (bank_sel != ptpr_pkg::BANK_PORT1)
			&& !corr_load |=> $stable(corr_high);
	endproperty
	a_bank_guard: assert property (p_bank_guard) else $error("wrong bank written");

	// the error flag is a pulse: it never stands without a drop behind it
	property p_frame_quiet;
		@(posedge hclk) disable iff (!hresetn)
		!rx_evt.chk_drop && !rx_evt.flt_drop |=> !rx_frame_error;
	endproperty
	a_frame_quiet: assert property (p_frame_quiet) else $error("spurious frame error");

	property p_flt_saturate;
		@(posedge hclk) disable iff (!hresetn)
		(flt_count == ptpr_pkg::COUNT_MAX) && !wr_flt |=> flt_count == ptpr_pkg::COUNT_MAX;
	endproperty
	a_flt_saturate: assert property (p_flt_saturate) else $error("filter count wrapped");

	property p_corr_low_write;
		@(posedge hclk) disable iff (!hresetn)
		wr_corr_low && !corr_load |=> corr_low == $past(hwdata[31:16]);
	endproperty
	a_corr_low_write: assert property (p_corr_low_write) else $error("low lost");

	property p_detect_write;
		@(posedge hclk) disable iff (!hresetn)
		wr_tx_detect
			|=> tx_detect == $past(hwdata[ptpr_pkg::TXD_L2_PEER:ptpr_pkg::TXD_PAIR_TWO]);
	endproperty
	a_detect_write: assert property (p_detect_write) else $error("enables lost");

	property p_gen_detect;
		@(posedge hclk) disable iff (!hresetn)
		tx_frame.valid && m_gen && en_gen |=> tx_is_ptp;
	endproperty
	a_gen_detect: assert property (p_gen_detect) else $error("general frame missed");

	property p_one_detect;
		@(posedge hclk) disable iff (!hresetn)
		tx_frame.valid && m_one && en_one |=> tx_is_ptp;
	endproperty
	a_one_detect: assert property (p_one_detect)
		else $error("pair one missed");

	property p_two_detect;
		@(posedge hclk) disable iff (!hresetn)
		tx_frame.valid && m_two && en_two |=> tx_is_ptp;
	endproperty
	a_two_detect: assert property (p_two_detect)
		else $error("pair two missed");

	property p_valid_follow;
		@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> tx_is_ptp_valid == $past(tx_frame.valid);
	endproperty
	a_valid_follow: assert property (p_valid_follow) else $error("verdict strobe lost");

	// frames of no known kind are never PTP, whatever the enables say
	property p_other_kind;
		@(posedge hclk) disable iff (!hresetn)
		tx_frame.valid && (tx_frame.kind == ptpr_pkg::KIND_OTHER) |=> !tx_is_ptp;
	endproperty
	a_other_kind: assert property (p_other_kind) else $error("unknown kind marked");

	c_capture: cover property (@(posedge hclk) disable iff (!hresetn) corr_load);
	c_saturated: cover property (@(posedge hclk) disable iff (!hresetn)
		rx_evt.chk_drop && (chk_count == ptpr_pkg::COUNT_MAX));
	c_tx_ptp: cover property (@(posedge hclk) disable iff (!hresetn) tx_is_ptp);
	c_clear_race: cover property (@(posedge hclk) disable iff (!hresetn)
		wr_flt && rx_evt.flt_drop);
endmodule // ptpr_regs

// File: tb.sv
`timescale 1ns/10ps
module tb;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] bank;
		logic [8:0] ofs;
		logic [31:0] wd;
		logic [31:0] exp;
	} ptpr_row_s;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	ptpr_pkg::ptpr_rx_evt_s rx_evt;
	logic rx_frame_error;
	ptpr_pkg::ptpr_tx_frame_s tx_frame;
	logic tx_is_ptp_valid;
	logic tx_is_ptp;
	logic [31:0] rd;
	int fails;
	int cmp_count;
	int cycles;
	ptpr_row_s rows [7];

	assign hready = hreadyout;

	ptpr_regs i_ptpr_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_evt(rx_evt),
		.rx_frame_error(rx_frame_error), .tx_frame(tx_frame),
		.tx_is_ptp_valid(tx_is_ptp_valid), .tx_is_ptp(tx_is_ptp));

	ptpr_mac_model i_ptpr_mac_model (.hclk(hclk), .rx_evt(rx_evt), .tx_frame(tx_frame));

	// ------------------------------------------------------------
	// clock and hang guard
	// ------------------------------------------------------------
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// whole run is a few hundred cycles; the ceiling leaves ample slack
	always @(posedge hclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			fails = fails + 1;
			$display("timeout at %0t", $time);
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			fails = fails + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// single non-pipelined transfer; read data taken at the data phase edge
	task automatic bus_xfer(input logic w, input logic [8:0] ofs, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {23'h0, ofs};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= w ? wd : 32'h0;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [2:0] bank, input logic [8:0] ofs, input logic [31:0] d);
		bus_xfer(1'b1, ptpr_pkg::OFS_BANK_SEL, {29'h0, bank});
		bus_xfer(1'b1, ofs, d);
	endtask

	task automatic rd_chk(input logic [2:0] bank, input logic [8:0] ofs, input logic [31:0] exp);
		bus_xfer(1'b1, ptpr_pkg::OFS_BANK_SEL, {29'h0, bank});
		bus_xfer(1'b0, ofs, 32'h0);
		chk(rd, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic tx_chk(input ptpr_pkg::ptpr_kind_e k, input logic [47:0] m,
		input logic [31:0] a4, input logic [127:0] a6, input logic exp);
		i_ptpr_mac_model.send_tx(k, m, a4, a6);
		@(posedge hclk);
		chk({31'h0, tx_is_ptp_valid}, 32'h1);
		chk({31'h0, tx_is_ptp}, {31'h0, exp});
	endtask

	task automatic rx_chk(input logic c, input logic f, input logic p, input logic [63:0] corr);
		i_ptpr_mac_model.send_rx(c, f, p, corr);
		@(posedge hclk);
		chk({31'h0, rx_frame_error}, {31'h0, c | f});
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		hresetn <= 1'b0;
		hsel <= 1'b0;
		haddr <= 32'h0;
		htrans <= 2'b00;
		hwrite <= 1'b0;
		hsize <= 3'h2;
		hwdata <= 32'h0;
		fails = 0;
		cmp_count = 0;
		cycles = 0;
		rows[0] = {3'h1, ptpr_pkg::OFS_CORR_HIGH, 32'hffff_ffff, 32'hffff_ffff};
		rows[1] = {3'h1, ptpr_pkg::OFS_CORR_LOW, 32'hffff_ffff, 32'hffff_0000};
		rows[2] = {3'h1, ptpr_pkg::OFS_CHK_DROP, 32'h1234_5678, 32'h1234_5678};
		rows[3] = {3'h1, ptpr_pkg::OFS_FLT_DROP, 32'h9abc_def0, 32'h9abc_def0};
		rows[4] = {3'h1, 9'h100, 32'hffff_ffff, 32'h0000_0000};
		rows[5] = {3'h2, ptpr_pkg::OFS_TX_DETECT, 32'hffff_ffff, 32'h0000_7800};
		rows[6] = {3'h2, ptpr_pkg::OFS_CORR_HIGH, 32'h5a5a_5a5a, 32'h0000_0000};
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// ordinary read/write cases, unmapped and wrong-bank places among them
		foreach (rows[i])
		begin
			wr(rows[i].bank, rows[i].ofs, rows[i].wd);
			rd_chk(rows[i].bank, rows[i].ofs, rows[i].exp);
		end
		$display("test register table done");

		// second reset in mid-run restores every documented default
		hresetn <= 1'b0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({31'h0, rx_frame_error}, 32'h0);
		bus_xfer(1'b0, ptpr_pkg::OFS_BANK_SEL, 32'h0);
		chk(rd, 32'h1);
		rd_chk(3'h1, ptpr_pkg::OFS_CORR_HIGH, 32'h0);
		rd_chk(3'h1, ptpr_pkg::OFS_CORR_LOW, 32'h0);
		rd_chk(3'h1, ptpr_pkg::OFS_CHK_DROP, 32'h0);
		rd_chk(3'h1, ptpr_pkg::OFS_FLT_DROP, 32'h0);
		rd_chk(3'h1, ptpr_pkg::OFS_REFRESH, 32'h0);
		rd_chk(3'h2, ptpr_pkg::OFS_TX_DETECT, 32'h0000_7000);
		$display("test reset values done");

		// transmit detection under the reset enables
		tx_chk(ptpr_pkg::KIND_L2, ptpr_pkg::MAC_L2_PEER, 32'h0, 128'h0, 1'b1);
		tx_chk(ptpr_pkg::KIND_L2, ptpr_pkg::MAC_L2_GEN, 32'h0, 128'h0, 1'b1);
		tx_chk(ptpr_pkg::KIND_IPV4, ptpr_pkg::MAC_V4_ONE, ptpr_pkg::IP4_ONE, 128'h0, 1'b1);
		tx_chk(ptpr_pkg::KIND_IPV6, ptpr_pkg::MAC_V6_ONE, 32'h0,
			{16'hff02, ptpr_pkg::IP6_ONE[111:0]}, 1'b1);
		tx_chk(ptpr_pkg::KIND_IPV4, ptpr_pkg::MAC_V4_TWO, ptpr_pkg::IP4_TWO, 128'h0, 1'b0);
		tx_chk(ptpr_pkg::KIND_IPV4, ptpr_pkg::MAC_V4_ONE, ptpr_pkg::IP4_TWO, 128'h0, 1'b0);
		tx_chk(ptpr_pkg::KIND_OTHER, ptpr_pkg::MAC_L2_PEER, 32'h0, 128'h0, 1'b0);
		// only pair two enabled; the other three detect enables cleared
		wr(3'h2, ptpr_pkg::OFS_TX_DETECT, 32'h0000_0800);
		tx_chk(ptpr_pkg::KIND_L2, ptpr_pkg::MAC_L2_PEER, 32'h0, 128'h0, 1'b0);
		tx_chk(ptpr_pkg::KIND_IPV4, ptpr_pkg::MAC_V4_TWO, ptpr_pkg::IP4_TWO, 128'h0, 1'b1);
		tx_chk(ptpr_pkg::KIND_IPV6, ptpr_pkg::MAC_V6_TWO, 32'h0, ptpr_pkg::IP6_TWO, 1'b1);
		tx_chk(ptpr_pkg::KIND_IPV4, ptpr_pkg::MAC_V4_ONE, ptpr_pkg::IP4_ONE, 128'h0, 1'b0);
		$display("test transmit detection done");

		// drop counters: saturation, clear by zero, independence
		wr(3'h1, ptpr_pkg::OFS_CHK_DROP, 32'hffff_fffe);
		rx_chk(1'b1, 1'b0, 1'b0, 64'h0);
		rx_chk(1'b1, 1'b0, 1'b0, 64'h0);
		rd_chk(3'h1, ptpr_pkg::OFS_CHK_DROP, 32'hffff_ffff);
		wr(3'h1, ptpr_pkg::OFS_CHK_DROP, 32'h0);
		rd_chk(3'h1, ptpr_pkg::OFS_CHK_DROP, 32'h0);
		wr(3'h1, ptpr_pkg::OFS_FLT_DROP, 32'hffff_fffe);
		rx_chk(1'b0, 1'b1, 1'b0, 64'h0);
		rx_chk(1'b1, 1'b1, 1'b0, 64'h0);
		rd_chk(3'h1, ptpr_pkg::OFS_FLT_DROP, 32'hffff_ffff);
		rd_chk(3'h1, ptpr_pkg::OFS_CHK_DROP, 32'h1);
		wr(3'h1, ptpr_pkg::OFS_FLT_DROP, 32'h0);
		rd_chk(3'h1, ptpr_pkg::OFS_FLT_DROP, 32'h0);
		$display("test drop counters done");

		// correction capture ignored while refresh is clear, then taken
		rx_chk(1'b0, 1'b0, 1'b1, 64'h1122_3344_5566_7788);
		rd_chk(3'h1, ptpr_pkg::OFS_CORR_HIGH, 32'h0);
		wr(3'h1, ptpr_pkg::OFS_REFRESH, 32'h8000_0000);
		rd_chk(3'h1, ptpr_pkg::OFS_REFRESH, 32'h8000_0000);
		rx_chk(1'b0, 1'b0, 1'b1, 64'h1122_3344_5566_7788);
		rd_chk(3'h1, ptpr_pkg::OFS_CORR_HIGH, 32'h1122_3344);
		rd_chk(3'h1, ptpr_pkg::OFS_CORR_LOW, 32'h5566_0000);
		$display("test correction capture done");
		complete_run();
	end
endmodule // tb
